// file: src/i2chs_pkg.sv
// package of constants and carrier types for the i2c hardware slave
package i2chs_pkg;

	// ******************************************************************
	// widths and reset values
	// ******************************************************************
	localparam int         DATA_W          = 8;
	localparam int         ADDR_W          = 7;
	localparam int         FIFO_DEPTH      = 16;
	localparam int         BIT_CNT_W       = 4;
	localparam logic [3:0] BIT_LAST        = 4'h8;
	localparam logic [6:0] OWN_ADDR_RST    = 7'h00;
	localparam logic [7:0] DATA_RST        = 8'h00;
	localparam logic       MASTER_SEL_RST  = 1'b0;
	localparam logic [15:0] IRQ_VECTOR     = 16'h003b;
	localparam int         SEC_IE_SERIAL_BIT = 0;
	localparam logic [7:0] SEC_IE_RST      = 8'ha0;

	// ******************************************************************
	// controller states, one-hot
	// ******************************************************************
	typedef enum logic [6:0] {
		ST_IDLE   = 7'b0000001,
		ST_ADDR   = 7'b0000010,
		ST_AACK   = 7'b0000100,
		ST_HOLD   = 7'b0001000,
		ST_RX     = 7'b0010000,
		ST_TX     = 7'b0100000,
		ST_HALT   = 7'b1000000
	} i2chs_state_e;

	// software-side control bits
	typedef struct packed {
		logic       master_select_bit;
		logic       interface_reset_bit;
		logic       serial_irq_enable;
		logic       global_irq_enable;
		logic [6:0] own_address_reg;
	} i2chs_ctrl_s;

	// software-side status bits
	typedef struct packed {
		logic byte_done_flag;
		logic transfer_direction_bit;
		logic halted;
		logic busy;
	} i2chs_stat_s;

endpackage

// file: src/i2chs_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module i2chs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic             flush_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);

	localparam int AW = $clog2(DEPTH);

	// ******************************************************************
	// checks
	// ******************************************************************
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("fifo depth must be a power of two, width positive");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	wire              full  = (wr_ptr[AW] != rd_ptr[AW]) &&
	                          (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire              empty = (wr_ptr == rd_ptr);
	wire              push  = in_valid_i && !full;
	wire              pop   = out_valid_o && out_ready_i;

	assign in_ready_o  = !full;
	assign out_valid_o = !empty;

	// storage write, no reset needed on the array
	always_ff @(posedge clock_i) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data_i;
	end

	wire [AW:0] next_rd = pop ? rd_ptr + 1'b1 : rd_ptr;
	// a push into the slot that becomes the head bypasses the array,
	// otherwise the registered head would show a stale word
	wire        bypass  = push && (wr_ptr == next_rd);

	// read data registered from the head so it is stable while shown
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			out_data_o <= '0;
		else if (bypass)
			out_data_o <= in_data_i;
		else
			out_data_o <= mem[next_rd[AW-1:0]];
	end

	// pointers; flush drops everything queued
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else if (flush_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			rd_ptr <= next_rd;
		end
	end

endmodule

`default_nettype wire

// file: src/i2chs_slave.sv
// i2c hardware slave controller with clock stretching and byte flag
//
// Overview of operation
// R1 - slave mode after reset when master-select clear
// R2 - own address comes from own_address_reg
// R3 - rx and tx bytes share serial_data_reg
// R4 - wait start, match address, set flag
// R5 - irq needs flag, serial and global enables
// R6 - data register access clears byte_done_flag
// R7 - second access per flag halts controller
// R8 - interrupt vector 003bh per complete byte
// R9 - first byte shows address and r/w
// R10 - direction bit holds master's r/w bit
// R11 - hold scl low until flag cleared
// R12 - master waits while clock held low
// R13 - flag only for acked bytes, not nack
// R14 - flag every byte until stop or reset
// R15 - stop returns controller to idle unless halted
// R16 - nack at end returns to idle
// R17 - interface reset forces idle, even halted
// R18 - serial irq enable is bit 0
// R19 - ack only own address, ignore others
// R20 - standard i2c timing, msb first
`timescale 1ns/1ps
`default_nettype none

module i2chs_slave #(
	parameter int TX_DEPTH = i2chs_pkg::FIFO_DEPTH
) (
	input  wire logic                  clock_i,
	input  wire logic                  rst_n_i,
	input  wire i2chs_pkg::i2chs_ctrl_s ctrl_i,
	input  wire logic [7:0]            secondary_irq_enable_reg_i,
	input  wire logic                  data_rd_i,
	input  wire logic                  data_wr_i,
	input  wire logic [7:0]            data_wdata_i,
	output logic                       tx_ready_o,
	output logic [7:0]                 serial_data_reg_o,
	output i2chs_pkg::i2chs_stat_s     status_o,
	output logic                       irq_o,
	output logic [15:0]                irq_vector_o,
	input  wire logic                  serial_clock_pin_i,
	output logic                       serial_clock_pin_o,
	output logic                       serial_clock_pin_oe_o,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe_o
);

	// ******************************************************************
	// checks
	// ******************************************************************
	initial begin
		if (TX_DEPTH < 2)
			$error("tx depth too small");
	end

	// ******************************************************************
	// pin synchronisers and edge detection
	// ******************************************************************
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_q;
	logic       sda_q;

	// two flops per pin, then one more stage for edges
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], serial_clock_pin_i};
			sda_sync <= {sda_sync[0], sda_i};
			scl_q    <= scl_sync[1];
			sda_q    <= sda_sync[1];
		end
	end

	wire scl      = scl_sync[1];
	wire sda      = sda_sync[1];
	wire scl_rise = scl && !scl_q;
	wire scl_fall = !scl && scl_q;
	wire start_c  = scl && scl_q && sda_q && !sda;
	wire stop_c   = scl && scl_q && !sda_q && sda;

	// ******************************************************************
	// state and datapath registers
	// ******************************************************************
	i2chs_pkg::i2chs_state_e state;
	i2chs_pkg::i2chs_state_e next_state;
	logic [7:0]  shift;
	logic [3:0]  bit_cnt;
	logic        dir;
	logic        flag;
	logic        accessed;
	logic        ack_phase;
	logic        drive_sda;
	logic [7:0]  data_reg;

	wire slave_en   = !ctrl_i.master_select_bit;                  // [R1]
	wire sw_access  = data_rd_i || data_wr_i;
	wire double_acc = sw_access && accessed;                      // [R7]
	wire soft_rst   = ctrl_i.interface_reset_bit;                 // [R17]
	wire addr_hit   = shift[7:1] == ctrl_i.own_address_reg;       // [R2] [R19]
	// received bytes end on the fall after the eighth rise; sent bytes
	// wait one clock more so the master's ack is in hand first
	wire rx_end     = scl_fall && bit_cnt == i2chs_pkg::BIT_LAST;
	wire tx_end     = scl_fall && bit_cnt == i2chs_pkg::BIT_LAST + 4'h1;

	// ******************************************************************
	// transmit queue; software writes land here
	// ******************************************************************
	logic [7:0] tx_head;
	logic       tx_valid;
	logic       tx_pop;

	// the fifo decouples software writes from the bit timing [R3]
	i2chs_fifo #(
		.WIDTH (i2chs_pkg::DATA_W),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.flush_i     (soft_rst || state == i2chs_pkg::ST_IDLE),
		.in_data_i   (data_wdata_i),
		.in_valid_i  (data_wr_i && dir && !double_acc),
		.in_ready_o  (tx_ready_o),
		.out_data_o  (tx_head),
		.out_valid_o (tx_valid),
		.out_ready_i (tx_pop)
	);

	// a transmit byte is loaded in the last held cycle, as the stretch is released
	assign tx_pop = state == i2chs_pkg::ST_HOLD && !flag && dir && tx_valid;

	// ******************************************************************
	// next state
	// ******************************************************************
	always_comb begin
		next_state = state;
		case (state)
			i2chs_pkg::ST_IDLE: begin
				if (start_c && slave_en)
					next_state = i2chs_pkg::ST_ADDR;             // [R4]
			end
			i2chs_pkg::ST_ADDR: begin
				if (rx_end)
					next_state = addr_hit ? i2chs_pkg::ST_AACK
					                      : i2chs_pkg::ST_IDLE;  // [R19]
			end
			i2chs_pkg::ST_AACK: begin
				if (scl_fall && ack_phase)
					next_state = i2chs_pkg::ST_HOLD;             // [R11]
			end
			i2chs_pkg::ST_HOLD: begin
				if (!flag && (!dir || tx_valid))
					next_state = dir ? i2chs_pkg::ST_TX
					                 : i2chs_pkg::ST_RX;         // [R10]
			end
			i2chs_pkg::ST_RX: begin
				if (rx_end)
					next_state = i2chs_pkg::ST_AACK;
			end
			i2chs_pkg::ST_TX: begin
				if (tx_end)
					next_state = shift[0] ? i2chs_pkg::ST_IDLE
					                 : i2chs_pkg::ST_HOLD;       // [R16]
			end
			i2chs_pkg::ST_HALT: next_state = i2chs_pkg::ST_HALT;
			default: next_state = i2chs_pkg::ST_IDLE;
		endcase
		if (double_acc)
			next_state = i2chs_pkg::ST_HALT;                     // [R7]
		if (start_c && slave_en && state != i2chs_pkg::ST_HALT)
			next_state = i2chs_pkg::ST_ADDR;
		if (stop_c && state != i2chs_pkg::ST_HALT)
			next_state = i2chs_pkg::ST_IDLE;                     // [R15]
		if (soft_rst || (!slave_en && state != i2chs_pkg::ST_HALT))
			next_state = i2chs_pkg::ST_IDLE;                     // [R17]
	end

	// state register
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			state <= i2chs_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// ******************************************************************
	// bit counter and shift register, msb first
	// ******************************************************************
	wire shifting = state == i2chs_pkg::ST_ADDR || state == i2chs_pkg::ST_RX ||
	                state == i2chs_pkg::ST_TX;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt <= 4'h0;
			shift   <= i2chs_pkg::DATA_RST;
		end else if (next_state == i2chs_pkg::ST_ADDR &&
		             state != i2chs_pkg::ST_ADDR) begin
			bit_cnt <= 4'h0;
		end else if (tx_pop) begin
			shift   <= tx_head;
			bit_cnt <= 4'h0;
		end else if (state == i2chs_pkg::ST_HOLD) begin
			bit_cnt <= 4'h0;
		end else if (shifting && scl_rise) begin
			shift   <= {shift[6:0], sda};                        // [R20]
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// ******************************************************************
	// ack phase, flag, direction and data register
	// ******************************************************************
	wire ack_ok = state == i2chs_pkg::ST_AACK && scl_fall && ack_phase;
	// the master's ack bit sits in shift[0] after the ninth rise
	wire tx_ack = state == i2chs_pkg::ST_TX && tx_end && !shift[0];

	// flag set wins over the auto-clear of the same cycle
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag     <= 1'b0;
			accessed <= 1'b0;
		end else if (soft_rst || next_state == i2chs_pkg::ST_IDLE) begin
			flag     <= 1'b0;
			accessed <= 1'b0;
		end else if (ack_ok || tx_ack) begin
			flag     <= 1'b1;                                    // [R4] [R13] [R14]
			accessed <= 1'b0;
		end else if (sw_access) begin
			flag     <= 1'b0;                                    // [R6]
			accessed <= 1'b1;
		end
	end

	// ack phase marks the ninth clock: set on the first rise after the eighth
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ack_phase <= 1'b0;
		else if (state != i2chs_pkg::ST_AACK)
			ack_phase <= 1'b0;
		else if (scl_rise)
			ack_phase <= 1'b1;
	end

	// direction latched from the address byte; data shown to software
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dir      <= 1'b0;
			data_reg <= i2chs_pkg::DATA_RST;
		end else if (state == i2chs_pkg::ST_ADDR && rx_end && addr_hit) begin
			dir      <= shift[0];                                // [R10]
			data_reg <= shift;                                   // [R9]
		end else if (state == i2chs_pkg::ST_RX && rx_end) begin
			data_reg <= shift;                                   // [R3]
		end else if (data_wr_i && !double_acc) begin
			data_reg <= data_wdata_i;
		end
	end

	// ******************************************************************
	// pin drive: open drain, enable means pull low
	// ******************************************************************
	// ack for every address match and every received byte; sent bytes
	// take their ack from the master instead
	wire ack_drive = state == i2chs_pkg::ST_AACK;
	// the first bit is set up while scl is still stretched, so sda never
	// moves after the release lets scl rise
	wire tx_drive  = (state == i2chs_pkg::ST_TX &&
	                  bit_cnt < i2chs_pkg::BIT_LAST && !shift[7]) ||
	                 (tx_pop && !tx_head[7]);

	// sda changes only while scl is low or in idle; registered to avoid glitches
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			drive_sda <= 1'b0;
		else if (!scl || state == i2chs_pkg::ST_IDLE)
			drive_sda <= ack_drive || tx_drive;                  // [R19] [R20]
	end

	assign sda_o                 = 1'b0;
	assign sda_oe_o              = drive_sda;
	assign serial_clock_pin_o    = 1'b0;
	assign serial_clock_pin_oe_o = state == i2chs_pkg::ST_HOLD ||
	                               state == i2chs_pkg::ST_HALT;  // [R11] [R12]

	// ******************************************************************
	// software view
	// ******************************************************************
	wire sec_ie = secondary_irq_enable_reg_i[i2chs_pkg::SEC_IE_SERIAL_BIT]; // [R18]

	assign serial_data_reg_o = data_reg;
	assign status_o.byte_done_flag         = flag;
	assign status_o.transfer_direction_bit = dir;
	assign status_o.halted  = state == i2chs_pkg::ST_HALT;
	assign status_o.busy    = state != i2chs_pkg::ST_IDLE;
	// polling stays possible with either enable clear
	assign irq_o        = flag && sec_ie && ctrl_i.serial_irq_enable &&
	                      ctrl_i.global_irq_enable;               // [R5]
	assign irq_vector_o = i2chs_pkg::IRQ_VECTOR;                 // [R8]

endmodule

`default_nettype wire

// file: verif/i2chs_slave_assertions.sv
// port assertions for the i2c hardware slave
`timescale 1ns/1ps
`default_nettype none

module i2chs_slave_assertions (
	input wire logic                   clock_i,
	input wire logic                   rst_n_i,
	input wire i2chs_pkg::i2chs_ctrl_s ctrl_i,
	input wire logic [7:0]             secondary_irq_enable_reg_i,
	input wire logic                   data_rd_i,
	input wire logic                   data_wr_i,
	input wire i2chs_pkg::i2chs_stat_s status_o,
	input wire logic                   irq_o,
	input wire logic [15:0]            irq_vector_o,
	input wire logic                   serial_clock_pin_i,
	input wire logic                   serial_clock_pin_o,
	input wire logic                   serial_clock_pin_oe_o,
	input wire logic                   sda_i,
	input wire logic                   sda_o
);
	// ******************************************************************
	// properties, all on the core clock
	// ******************************************************************
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_irq_gating: assert property (
		irq_o == (status_o.byte_done_flag && ctrl_i.serial_irq_enable &&
		ctrl_i.global_irq_enable && secondary_irq_enable_reg_i[0]))
		else $error("irq differs from flag and enables");
	a_vector_fixed: assert property (irq_vector_o == 16'h003b)
		else $error("irq vector wrong");
	a_access_clears: assert property (
		status_o.byte_done_flag && (data_rd_i || data_wr_i)
		|=> !status_o.byte_done_flag) else $error("flag not cleared");
	a_stretch_hold: assert property (
		status_o.byte_done_flag && $past(status_o.byte_done_flag)
		|-> serial_clock_pin_oe_o) else $error("scl released early");
	a_halt_hold: assert property (
		status_o.halted |-> serial_clock_pin_oe_o)
		else $error("halted without scl held");
	a_reset_idles: assert property (
		ctrl_i.interface_reset_bit
		|-> ##[1:3] !status_o.halted && !status_o.byte_done_flag)
		else $error("interface reset ignored");
	a_open_drain: assert property (
		!serial_clock_pin_o && !sda_o) else $error("pin driven high");
	a_stop_idles: assert property (
		$rose(sda_i) && serial_clock_pin_i && $past(serial_clock_pin_i)
		|-> ##[1:8] !status_o.busy && !status_o.byte_done_flag)
		else $error("no idle after stop");
	a_flag_busy: assert property (
		$rose(status_o.byte_done_flag) |-> status_o.busy && !status_o.halted)
		else $error("flag outside a transfer");
endmodule

bind i2chs_slave i2chs_slave_assertions u_i2chs_slave_assertions (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl_i),
	.secondary_irq_enable_reg_i(secondary_irq_enable_reg_i),
	.data_rd_i(data_rd_i), .data_wr_i(data_wr_i), .status_o(status_o),
	.irq_o(irq_o), .irq_vector_o(irq_vector_o),
	.serial_clock_pin_i(serial_clock_pin_i),
	.serial_clock_pin_o(serial_clock_pin_o),
	.serial_clock_pin_oe_o(serial_clock_pin_oe_o),
	.sda_i(sda_i), .sda_o(sda_o));
`default_nettype wire

// file: verif/i2chs_master_model.sv
// behavioural i2c bus master, open-drain pulls only
`timescale 1ns/1ps
`default_nettype none

module i2chs_master_model (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_oe_o,
	output logic      sda_oe_o
);
	// both lines released, so they sit at the pull-up level
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	// release scl, wait out any stretch, then a high half period
	task automatic rise();
		int n;
		n = 0;
		scl_oe_o = 1'b0;
		while (!scl_i && n < 4000) begin
			#5;
			n++;
		end
		#62.5;
	endtask
	task automatic fall();
		scl_oe_o = 1'b1;
		#31.25;
	endtask
	// data only changes while scl is low
	task automatic put_bit(input logic b);
		sda_oe_o = !b;
		#31.25;
		rise();
		fall();
	endtask
	task automatic get_bit(output logic b);
		sda_oe_o = 1'b0;
		#31.25;
		rise();
		b = sda_i;
		fall();
	endtask
	task automatic start();
		#62.5;
		sda_oe_o = 1'b1;
		#62.5;
		fall();
	endtask
	task automatic stop();
		sda_oe_o = 1'b1;
		#31.25;
		rise();
		sda_oe_o = 1'b0;
		#62.5;
	endtask
	// msb first, ack is the ninth bit pulled low
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(b);
		ack = !b;
	endtask
	task automatic recv_byte(output logic [7:0] d, input logic nack);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(nack);
	endtask
endmodule
`default_nettype wire

// file: verif/tb_i2chs_slave.sv
// bench for the i2c slave against a behavioural bus master
`timescale 1ns/1ps
`default_nettype none

module tb_i2chs_slave;
	logic                   clock_i, rst_n_i, rd, wr, tx_rdy, irq, ack;
	logic                   flag_q, scl_o, scl_oe, sda_o, sda_oe;
	logic                   m_scl, m_sda;
	i2chs_pkg::i2chs_ctrl_s ctrl;
	i2chs_pkg::i2chs_stat_s stat;
	logic [7:0]             sec_ie, wdata, rdata, d, got;
	logic [15:0]            vec;
	logic [6:0]             a;
	int                     bad_count, checks_done, cyc, n;
	logic [8:0]             exp_q[$];
	// wired-and lines with pull-ups
	wire logic              scl = !((scl_oe && !scl_o) || m_scl);
	wire logic              sda = !((sda_oe && !sda_o) || m_sda);

	i2chs_slave u_i2chs_slave (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl),
		.secondary_irq_enable_reg_i(sec_ie), .data_rd_i(rd),
		.data_wr_i(wr), .data_wdata_i(wdata), .tx_ready_o(tx_rdy),
		.serial_data_reg_o(rdata), .status_o(stat), .irq_o(irq),
		.irq_vector_o(vec), .serial_clock_pin_i(scl),
		.serial_clock_pin_o(scl_o), .serial_clock_pin_oe_o(scl_oe),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe));
	i2chs_master_model u_i2chs_master_model (.scl_i(scl), .sda_i(sda),
		.scl_oe_o(m_scl), .sda_oe_o(m_sda));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// leaves inputs 1 ns past an edge so master events miss clock edges
	task automatic idle(int c);
		repeat (c) @(posedge clock_i);
		#1;
	endtask
	// one-cycle software access to the data register
	task automatic acc(logic w, logic [7:0] v);
		idle(1);
		rd = !w;
		wr = w;
		wdata = v;
		idle(1);
		rd = 1'b0;
		wr = 1'b0;
	endtask
	task automatic wait_flag();
		n = 0;
		while (stat.byte_done_flag !== 1'b1 && n < 200) begin
			@(posedge clock_i);
			n++;
		end
		#1;
		chk("flag raised", 16'h1, {15'h0, stat.byte_done_flag});
		chk("scl stretch", 16'h1, {15'h0, scl_oe});
	endtask

	// monitor: each new flag takes the oldest expected {dir, data}
	always @(posedge clock_i) begin
		if (rst_n_i && stat.byte_done_flag && !flag_q) begin
			if (exp_q.size() == 0) begin
				chk("unexpected flag", 16'h0, 16'h1);
			end else begin
				chk("data reg", {7'h0, exp_q.pop_front()},
					{7'h0, stat.transfer_direction_bit, rdata});
			end
		end
		flag_q <= stat.byte_done_flag;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			stop_test();
		end
	end

	initial begin
		{rst_n_i, rd, wr, ctrl, wdata} = '0;
		{bad_count, checks_done} = '0;
		sec_ie = 8'ha1;
		a = 7'($urandom(25)) | 7'h01;
		ctrl.own_address_reg = a;
		ctrl.serial_irq_enable = 1'b1;
		idle(6);
		rst_n_i = 1'b1;
		chk("vector", 16'h003b, vec);
		// write transfer: address then three data bytes
		u_i2chs_master_model.start();
		exp_q.push_back({1'b0, a, 1'b0});
		u_i2chs_master_model.send_byte({a, 1'b0}, ack);
		chk("addr ack", 16'h1, {15'h0, ack});
		wait_flag();
		acc(1'b0, 8'h00);
		for (int j = 0; j < 3; j++) begin
			d = $urandom;
			exp_q.push_back({1'b0, d});
			ctrl.global_irq_enable = j[0];
			u_i2chs_master_model.send_byte(d, ack);
			chk("data ack", 16'h1, {15'h0, ack});
			wait_flag();
			chk("irq", {15'h0, j[0]}, {15'h0, irq});
			acc(1'b0, 8'h00);
		end
		u_i2chs_master_model.stop();
		idle(8);
		chk("busy after stop", 16'h0, {15'h0, stat.busy});
		$display("test write done");
		// foreign address, then own address while master mode is set
		for (int k = 0; k < 2; k++) begin
			idle(1);
			ctrl.master_select_bit = k[0];
			u_i2chs_master_model.start();
			u_i2chs_master_model.send_byte({a ^ {6'h0, !k[0]}, 1'b0}, ack);
			chk("ignored ack", 16'h0, {15'h0, ack});
			u_i2chs_master_model.stop();
		end
		idle(1);
		ctrl.master_select_bit = 1'b0;
		$display("test ignore done");
		// read transfer ended by the master's nack
		u_i2chs_master_model.start();
		exp_q.push_back({1'b1, a, 1'b1});
		u_i2chs_master_model.send_byte({a, 1'b1}, ack);
		chk("read ack", 16'h1, {15'h0, ack});
		wait_flag();
		d = $urandom;
		acc(1'b1, d);
		u_i2chs_master_model.recv_byte(got, 1'b1);
		chk("sent byte", {8'h0, d}, {8'h0, got});
		idle(8);
		chk("busy after nack", 16'h0, {15'h0, stat.busy});
		u_i2chs_master_model.stop();
		$display("test read done");
		// a second access for one flag halts until the interface reset
		u_i2chs_master_model.start();
		exp_q.push_back({1'b1, a, 1'b1});
		u_i2chs_master_model.send_byte({a, 1'b1}, ack);
		chk("halt addr ack", 16'h1, {15'h0, ack});
		wait_flag();
		n = 0;
		while (stat.halted !== 1'b1 && n < 20) begin
			acc(1'b1, 8'(n));
			n++;
		end
		chk("fifo ready", 16'h1, {15'h0, tx_rdy});
		chk("accesses to halt", 16'h2, 16'(n));
		chk("halted", 16'h1, {15'h0, stat.halted});
		ctrl.interface_reset_bit = 1'b1;
		idle(3);
		ctrl.interface_reset_bit = 1'b0;
		idle(3);
		chk("halt cleared", 16'h0, {15'h0, stat.halted});
		chk("scl released", 16'h0, {15'h0, scl_oe});
		u_i2chs_master_model.stop();
		$display("test halt done");
		chk("pending flags", 16'h0, 16'(exp_q.size()));
		stop_test();
	end
endmodule
`default_nettype wire
